// ### verilog/ebm_consts.vh
/*
 Constants for the dual port block memory: geometry, register offsets,
 control field positions, reset values and bus response codes.
 Assumes it is included by bare name from every design file that needs it.
*/
`ifndef EBM_CONSTS_VH
`define EBM_CONSTS_VH

// Array geometry
`define EBM_DW 16
`define EBM_AW 8
`define EBM_DEPTH 256

// Register byte offsets on the bus
`define EBM_BUS_AW 4
`define EBM_OFF_CTRL 4'h0
`define EBM_OFF_LOAD_ADDR 4'h4
`define EBM_OFF_LOAD_DATA 4'h8
`define EBM_OFF_WR_COUNT 4'hC

// Control register fields
`define EBM_CTRL_W 4
`define EBM_CTRL_CFG 0
`define EBM_CTRL_WR_FALL 1
`define EBM_CTRL_RD_FALL 2
`define EBM_CTRL_ROM 3
`define EBM_CTRL_RST 4'h1

// Reset values and steps
`define EBM_LOAD_ADDR_RST 8'h00
`define EBM_LOAD_ADDR_STEP 8'h01
`define EBM_WR_COUNT_RST 16'h0000
`define EBM_WR_COUNT_STEP 16'h0001
`define EBM_WORD_RST 16'h0000
`define EBM_BUS_RST 32'h00000000

// Bus response codes
`define EBM_RESP_OKAY 2'h0
`define EBM_RESP_SLVERR 2'h2

`endif

// ### verilog/ebm_edge_pick.v
/*
 Active edge detector for a port clock that arrives as a plain level.
 Assumes the level is synchronous to clk and held at least one clk cycle
 per phase.
*/
`timescale 1ns/1ps

module ebm_edge_pick (
	input wire clk,
	input wire resetn,
	input wire level,
	input wire falling_sel,
	output wire hit
);

reg prev_ff;

always @(posedge clk or negedge resetn) begin
	if (!resetn) begin
		prev_ff <= 1'b0;
	end else begin
		prev_ff <= level;
	end
end

// Changing falling_sel while the level is steady gives no stray edge
assign hit = falling_sel ? (prev_ff & ~level) : (~prev_ff & level);

endmodule // ebm_edge_pick

// ### verilog/ebm_block_memory.v
/*
 Dual port 256x16 block memory with an AXI4-Lite slave for preload and
 control. The write and read port clocks arrive as levels sampled on clk.
 Assumes all user inputs and port clocks are synchronous to clk, and that
 software clears the configuration bit once preload is done.
*/
// Our own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`include "ebm_consts.vh"

//////////////////////////////////////////////////////////////////////////////
module ebm_block_memory (
	input wire clk,
	input wire resetn,
	input wire [`EBM_BUS_AW-1:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output wire [1:0] s_axi_bresp,
	output wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [`EBM_BUS_AW-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0] s_axi_rresp,
	output wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire wr_clk,
	input wire [`EBM_DW-1:0] wr_data,
	input wire [`EBM_DW-1:0] wr_mask,
	input wire [`EBM_AW-1:0] wr_location,
	input wire wr_en,
	input wire wr_clock_gate,
	input wire rd_clk,
	input wire [`EBM_AW-1:0] rd_location,
	input wire rd_allow,
	input wire rd_clock_gate,
	output wire [`EBM_DW-1:0] rd_data
);

//////////////////////////////////////////////////////////////////////////////
// Storage and state

// No reset on the array: contents only come from preload or user writes
reg [`EBM_DW-1:0] mem [0:`EBM_DEPTH-1];

reg [`EBM_CTRL_W-1:0] ctrl_ff;
reg [`EBM_AW-1:0] load_addr_ff;
reg [`EBM_DW-1:0] wr_count_ff;

reg aw_held_ff;
reg [`EBM_BUS_AW-1:0] aw_addr_ff;
reg w_held_ff;
reg [31:0] w_data_ff;
reg [3:0] w_strb_ff;
reg bvalid_ff;
reg [1:0] bresp_ff;
reg rvalid_ff;
reg [31:0] rdata_ff;
reg [1:0] rresp_ff;

reg [`EBM_AW-1:0] wr_addr_ff;
reg [`EBM_DW-1:0] wr_data_ff;
reg [`EBM_DW-1:0] wr_mask_ff;
reg wr_apply_ff;
reg [`EBM_AW-1:0] rd_addr_ff;
reg rd_go_ff;
reg [`EBM_DW-1:0] rd_data_ff;

wire cfg_mode;
wire rom_lock;
wire wr_hit;
wire rd_hit;
wire do_write;
wire load_hit;
wire [`EBM_DW-1:0] load_word;
wire [`EBM_DW-1:0] load_merged;
wire [`EBM_DW-1:0] user_merged;
reg [31:0] nxt_rdata;
reg [1:0] nxt_rresp;
reg [1:0] nxt_bresp;

assign cfg_mode = ctrl_ff[`EBM_CTRL_CFG];
assign rom_lock = ctrl_ff[`EBM_CTRL_ROM];

//////////////////////////////////////////////////////////////////////////////
// Port clock edges

ebm_edge_pick u_wr_edge (
	.clk(clk),
	.resetn(resetn),
	.level(wr_clk),
	.falling_sel(ctrl_ff[`EBM_CTRL_WR_FALL]),
	.hit(wr_hit)
);

ebm_edge_pick u_rd_edge (
	.clk(clk),
	.resetn(resetn),
	.level(rd_clk),
	.falling_sel(ctrl_ff[`EBM_CTRL_RD_FALL]),
	.hit(rd_hit)
);

//////////////////////////////////////////////////////////////////////////////
// AXI4-Lite write channel

assign s_axi_awready = ~aw_held_ff & ~bvalid_ff;
assign s_axi_wready = ~w_held_ff & ~bvalid_ff;
assign s_axi_bvalid = bvalid_ff;
assign s_axi_bresp = bresp_ff;
assign do_write = aw_held_ff & w_held_ff & ~bvalid_ff;
assign load_hit = do_write & cfg_mode & (aw_addr_ff == `EBM_OFF_LOAD_DATA);

always @* begin
	nxt_bresp = `EBM_RESP_OKAY;
	case (aw_addr_ff)
		`EBM_OFF_CTRL: nxt_bresp = `EBM_RESP_OKAY;
		`EBM_OFF_LOAD_ADDR: nxt_bresp = `EBM_RESP_OKAY;
		// Preload outside configuration mode is refused
		`EBM_OFF_LOAD_DATA: nxt_bresp = cfg_mode ? `EBM_RESP_OKAY : `EBM_RESP_SLVERR;
		`EBM_OFF_WR_COUNT: nxt_bresp = `EBM_RESP_OKAY;
		default: nxt_bresp = `EBM_RESP_SLVERR;
	endcase
end

always @(posedge clk or negedge resetn) begin
	if (!resetn) begin
		aw_held_ff <= 1'b0;
		aw_addr_ff <= `EBM_OFF_CTRL;
		w_held_ff <= 1'b0;
		w_data_ff <= `EBM_BUS_RST;
		w_strb_ff <= 4'h0;
		bvalid_ff <= 1'b0;
		bresp_ff <= `EBM_RESP_OKAY;
	end else begin
		if (s_axi_awvalid && s_axi_awready) begin
			aw_held_ff <= 1'b1;
			aw_addr_ff <= s_axi_awaddr;
		end else if (do_write) begin
			aw_held_ff <= 1'b0;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_held_ff <= 1'b1;
			w_data_ff <= s_axi_wdata;
			w_strb_ff <= s_axi_wstrb;
		end else if (do_write) begin
			w_held_ff <= 1'b0;
		end
		if (do_write) begin
			bvalid_ff <= 1'b1;
			bresp_ff <= nxt_bresp;
		end else if (s_axi_bready) begin
			bvalid_ff <= 1'b0;
		end
	end
end

//////////////////////////////////////////////////////////////////////////////
// Control registers

always @(posedge clk or negedge resetn) begin
	if (!resetn) begin
		ctrl_ff <= `EBM_CTRL_RST;
		load_addr_ff <= `EBM_LOAD_ADDR_RST;
		wr_count_ff <= `EBM_WR_COUNT_RST;
	end else begin
		if (do_write && aw_addr_ff == `EBM_OFF_CTRL && w_strb_ff[0]) begin
			ctrl_ff <= w_data_ff[`EBM_CTRL_W-1:0];
		end
		if (do_write && aw_addr_ff == `EBM_OFF_LOAD_ADDR && w_strb_ff[0]) begin
			load_addr_ff <= w_data_ff[`EBM_AW-1:0];
		end else if (load_hit) begin
			// Auto step lets software stream the whole image
			load_addr_ff <= load_addr_ff + `EBM_LOAD_ADDR_STEP;
		end
		if (wr_apply_ff) begin
			wr_count_ff <= wr_count_ff + `EBM_WR_COUNT_STEP;
		end
	end
end

//////////////////////////////////////////////////////////////////////////////
// User port input registers

always @(posedge clk or negedge resetn) begin
	if (!resetn) begin
		wr_addr_ff <= `EBM_LOAD_ADDR_RST;
		wr_data_ff <= `EBM_WORD_RST;
		wr_mask_ff <= `EBM_WORD_RST;
		wr_apply_ff <= 1'b0;
		rd_addr_ff <= `EBM_LOAD_ADDR_RST;
		rd_go_ff <= 1'b0;
	end else begin
		if (wr_hit) begin
			wr_addr_ff <= wr_location;
			wr_data_ff <= wr_data;
			wr_mask_ff <= wr_mask;
		end
		// Blocked in configuration and in ROM mode
		wr_apply_ff <= wr_hit & wr_en & wr_clock_gate & ~cfg_mode & ~rom_lock;
		if (rd_hit) begin
			rd_addr_ff <= rd_location;
		end
		rd_go_ff <= rd_hit & rd_allow & rd_clock_gate & ~cfg_mode;
	end
end

//////////////////////////////////////////////////////////////////////////////
// Array write and read

assign load_word = mem[load_addr_ff];
assign load_merged = {w_strb_ff[1] ? w_data_ff[15:8] : load_word[15:8],
	w_strb_ff[0] ? w_data_ff[7:0] : load_word[7:0]};
assign user_merged = (mem[wr_addr_ff] & wr_mask_ff) | (wr_data_ff & ~wr_mask_ff);

// Preload and user writes never meet: user writes stop in configuration mode
always @(posedge clk) begin
	if (load_hit) begin
		mem[load_addr_ff] <= load_merged;
	end else if (wr_apply_ff) begin
		mem[wr_addr_ff] <= user_merged;
	end
end

always @(posedge clk or negedge resetn) begin
	if (!resetn) begin
		rd_data_ff <= `EBM_WORD_RST;
	end else if (rd_go_ff) begin
		rd_data_ff <= mem[rd_addr_ff];
	end
end

assign rd_data = rd_data_ff;

//////////////////////////////////////////////////////////////////////////////
// AXI4-Lite read channel

assign s_axi_arready = ~rvalid_ff;
assign s_axi_rvalid = rvalid_ff;
assign s_axi_rdata = rdata_ff;
assign s_axi_rresp = rresp_ff;

always @* begin
	nxt_rdata = `EBM_BUS_RST;
	nxt_rresp = `EBM_RESP_OKAY;
	case (s_axi_araddr)
		`EBM_OFF_CTRL: nxt_rdata = {28'h0000000, ctrl_ff};
		`EBM_OFF_LOAD_ADDR: nxt_rdata = {24'h000000, load_addr_ff};
		`EBM_OFF_LOAD_DATA: nxt_rdata = {16'h0000, load_word};
		`EBM_OFF_WR_COUNT: nxt_rdata = {16'h0000, wr_count_ff};
		default: nxt_rresp = `EBM_RESP_SLVERR;
	endcase
end

always @(posedge clk or negedge resetn) begin
	if (!resetn) begin
		rvalid_ff <= 1'b0;
		rdata_ff <= `EBM_BUS_RST;
		rresp_ff <= `EBM_RESP_OKAY;
	end else begin
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_ff <= 1'b1;
			rdata_ff <= nxt_rdata;
			rresp_ff <= nxt_rresp;
		end else if (s_axi_rready) begin
			rvalid_ff <= 1'b0;
		end
	end
end

endmodule // ebm_block_memory

// ### tb/ebm_block_memory_chk.sv
/*
 Checker for the block memory: bus handshakes and read port holding.
 Assumes it is bound to the top module and sees its ports only.
*/
`timescale 1ns/1ps

module ebm_block_memory_chk (
	input wire clk,
	input wire resetn,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire rd_clk,
	input wire rd_allow,
	input wire rd_clock_gate,
	input wire [15:0] rd_data
);
reg rd_clk_ff;
wire rd_fire;
// Either direction counts, so any edge select is covered
assign rd_fire = (rd_clk != rd_clk_ff) && rd_allow && rd_clock_gate;
always @(posedge clk or negedge resetn) begin
	if (!resetn) begin
		rd_clk_ff <= 1'h0;
	end else begin
		rd_clk_ff <= rd_clk;
	end
end
default clocking cb @(posedge clk); endclocking
default disable iff (!resetn);
sequence both_taken;
	s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
endsequence
sequence b_late;
	!s_axi_bvalid ##1 s_axi_bvalid;
endsequence
b_delay_a: assert property (both_taken |=> b_late)
	else $error("write answer not one cycle late");
r_delay_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
	else $error("read answer late");
b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
	else $error("write answer dropped");
r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
	else $error("read answer dropped");
b_drop_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
	else $error("write answer repeated");
ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
	else $error("read taken while busy");
aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
	else $error("write taken while busy");
rd_keep_a: assert property (!$past(rd_fire) && !$past(rd_fire, 2) |-> $stable(rd_data))
	else $error("read data moved without read");
endmodule // ebm_block_memory_chk

bind ebm_block_memory ebm_block_memory_chk chk (.*);

// ### tb/ebm_user_side.sv
/*
 User logic model driving the write and read ports.
 Assumes its tasks are called just after a clk edge.
*/
`timescale 1ns/1ps

module ebm_user_side (
	input wire clk,
	output reg wr_clk,
	output reg [15:0] wr_data,
	output reg [15:0] wr_mask,
	output reg [7:0] wr_location,
	output reg wr_en,
	output reg wr_clock_gate,
	output reg rd_clk,
	output reg [7:0] rd_location,
	output reg rd_allow,
	output reg rd_clock_gate
);
initial begin
	{wr_clk, wr_data, wr_mask, wr_location, wr_en, wr_clock_gate} = 43'h0;
	{rd_clk, rd_location, rd_allow, rd_clock_gate} = 11'h0;
end
// Second value changes mid phase, so only the falling mode takes it
task wr(input [7:0] a, input [15:0] d1, input [15:0] d2, input [15:0] m, input e, input g);
	begin
		{wr_location, wr_data, wr_mask, wr_en, wr_clock_gate} <= {a, d1, m, e, g};
		wr_clk <= 1'h1;
		repeat (2) @(posedge clk);
		wr_data <= d2;
		@(posedge clk);
		wr_clk <= 1'h0;
		repeat (3) @(posedge clk);
		{wr_en, wr_clock_gate} <= 2'h0;
		// Let an edge pass so a following call never re-drives in the same step
		@(posedge clk);
	end
endtask
// One block per model; a wider memory decodes and muxes outside the block
task rd(input [7:0] a1, input [7:0] a2, input al, input g);
	begin
		{rd_location, rd_allow, rd_clock_gate} <= {a1, al, g};
		rd_clk <= 1'h1;
		repeat (2) @(posedge clk);
		rd_location <= a2;
		@(posedge clk);
		rd_clk <= 1'h0;
		repeat (3) @(posedge clk);
		{rd_allow, rd_clock_gate} <= 2'h0;
		@(posedge clk);
	end
endtask
endmodule // ebm_user_side

// ### tb/ebm_block_memory_bench.sv
/*
 Bench for the block memory: bus tasks, user port traffic, checks.
 Assumes the user side model drives every user port.
*/
`timescale 1ns/1ps
`include "ebm_consts.vh"

module ebm_block_memory_bench;
reg clk;
reg resetn;
reg [3:0] s_axi_awaddr;
reg [31:0] s_axi_wdata;
reg [3:0] s_axi_araddr;
reg s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
wire [1:0] s_axi_bresp, s_axi_rresp;
wire [31:0] s_axi_rdata;
wire [15:0] rd_data, wr_data, wr_mask;
wire [7:0] wr_location, rd_location;
wire wr_clk, rd_clk, wr_en, wr_clock_gate, rd_allow, rd_clock_gate;
integer errors;
integer comparisons;
reg ta, tw, tv, got;
reg [31:0] seen;
reg [1:0] seen_resp;
ebm_block_memory dut (.*, .s_axi_wstrb(4'hF));
ebm_user_side far (.*);
////////////////////////////////////////////////////////////
task check(input [31:0] s, input [31:0] e);
	begin
		comparisons = comparisons + 1;
		if (s !== e) begin
			errors = errors + 1;
			$display("mismatch at %0t: saw %h expected %h", $time, s, e);
		end
	end
endtask
task axi_wr(input [3:0] a, input [31:0] d, input [1:0] r);
	begin
		{s_axi_awaddr, s_axi_wdata} <= {a, d};
		{s_axi_awvalid, s_axi_wvalid} <= 2'h3;
		got = 1'h0;
		while (!got) begin
			@(negedge clk);
			ta = s_axi_awvalid & s_axi_awready;
			tw = s_axi_wvalid & s_axi_wready;
			tv = s_axi_bvalid;
			got = s_axi_bvalid & s_axi_bready;
			seen = {30'h0, s_axi_bresp};
			@(posedge clk);
			if (ta) s_axi_awvalid <= 1'h0;
			if (tw) s_axi_wvalid <= 1'h0;
			// Answer waits one cycle so that its hold is exercised
			if (tv && !got) s_axi_bready <= 1'h1;
		end
		s_axi_bready <= 1'h0;
		check(seen, {30'h0, r});
	end
endtask
task axi_rd(input [3:0] a, input [31:0] e, input [1:0] r);
	begin
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		got = 1'h0;
		while (!got) begin
			@(negedge clk);
			ta = s_axi_arvalid & s_axi_arready;
			tv = s_axi_rvalid;
			got = s_axi_rvalid & s_axi_rready;
			seen = s_axi_rdata;
			seen_resp = s_axi_rresp;
			@(posedge clk);
			if (ta) s_axi_arvalid <= 1'h0;
			if (tv && !got) s_axi_rready <= 1'h1;
		end
		s_axi_rready <= 1'h0;
		check(seen, e);
		check({30'h0, seen_resp}, {30'h0, r});
	end
endtask
task urd(input [7:0] a1, input [7:0] a2, input al, input g, input [15:0] e);
	begin
		far.rd(a1, a2, al, g);
		check({16'h0, rd_data}, {16'h0, e});
	end
endtask
task finish_test;
	begin
		if (errors == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	end
endtask
////////////////////////////////////////////////////////////
initial begin
	clk = 1'h0;
	forever #12.5 clk = ~clk;
end
initial begin
	repeat (3000) @(posedge clk);
	errors = errors + 1;
	finish_test;
end
initial begin
	errors = 0;
	comparisons = 0;
	resetn = 1'h0;
	{s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 40'h0;
	{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
	repeat (8) @(posedge clk);
	resetn <= 1'h1;
	@(posedge clk);
	axi_rd(`EBM_OFF_CTRL, 32'h00000001, `EBM_RESP_OKAY);
	axi_wr(`EBM_OFF_LOAD_ADDR, 32'h000000FE, `EBM_RESP_OKAY);
	axi_wr(`EBM_OFF_LOAD_DATA, 32'h00001234, `EBM_RESP_OKAY);
	axi_wr(`EBM_OFF_LOAD_DATA, 32'h0000ABCD, `EBM_RESP_OKAY);
	axi_wr(`EBM_OFF_LOAD_DATA, 32'h00005A5A, `EBM_RESP_OKAY);
	axi_rd(`EBM_OFF_LOAD_ADDR, 32'h00000001, `EBM_RESP_OKAY);
	axi_wr(`EBM_OFF_LOAD_ADDR, 32'h000000FF, `EBM_RESP_OKAY);
	axi_rd(`EBM_OFF_LOAD_DATA, 32'h0000ABCD, `EBM_RESP_OKAY);
	axi_wr(`EBM_OFF_WR_COUNT, 32'h00000009, `EBM_RESP_OKAY);
	axi_wr(4'h2, 32'h00000000, `EBM_RESP_SLVERR);
	axi_rd(4'h2, 32'h00000000, `EBM_RESP_SLVERR);
	axi_wr(`EBM_OFF_CTRL, 32'h00000000, `EBM_RESP_OKAY);
	axi_wr(`EBM_OFF_LOAD_DATA, 32'h00001111, `EBM_RESP_SLVERR);
	urd(8'hFE, 8'h00, 1'h1, 1'h1, 16'h1234);
	far.wr(8'hFE, 16'hFFFF, 16'h0000, 16'hFF00, 1'h1, 1'h1);
	urd(8'hFE, 8'hFF, 1'h1, 1'h1, 16'h12FF);
	urd(8'hFF, 8'hFE, 1'h1, 1'h1, 16'hABCD);
	far.wr(8'hFE, 16'h0000, 16'h0000, 16'h0000, 1'h0, 1'h1);
	far.wr(8'hFE, 16'h0000, 16'h0000, 16'h0000, 1'h1, 1'h0);
	urd(8'hFE, 8'hFE, 1'h1, 1'h1, 16'h12FF);
	urd(8'h00, 8'h00, 1'h0, 1'h1, 16'h12FF);
	urd(8'h00, 8'h00, 1'h1, 1'h0, 16'h12FF);
	axi_wr(`EBM_OFF_CTRL, 32'h00000006, `EBM_RESP_OKAY);
	far.wr(8'h00, 16'h1111, 16'h2222, 16'h0000, 1'h1, 1'h1);
	urd(8'hFE, 8'h00, 1'h1, 1'h1, 16'h2222);
	axi_wr(`EBM_OFF_CTRL, 32'h00000008, `EBM_RESP_OKAY);
	far.wr(8'h00, 16'h7777, 16'h7777, 16'h0000, 1'h1, 1'h1);
	urd(8'h00, 8'hFE, 1'h1, 1'h1, 16'h2222);
	axi_rd(`EBM_OFF_WR_COUNT, 32'h00000002, `EBM_RESP_OKAY);
	finish_test;
end
endmodule // ebm_block_memory_bench
